//--- rtl/mde_pkg.sv
// Constants, register map and carrier types of the motion event detector.
// Assumes one 10 MHz system clock and a same-clock sample source.
package mde_pkg;

	// Register offsets
	localparam logic [7:0] MDE_OFS_STATUS     = 8'h12;
	localparam logic [7:0] MDE_OFS_OPERATING_MODE_SELECT    = 8'h26;
	localparam logic [7:0] MDE_OFS_CHAN_EN    = 8'h27;
	localparam logic [7:0] MDE_OFS_MAP_A_LO   = 8'h2b;
	localparam logic [7:0] MDE_OFS_MAP_A_HI   = 8'h2c;
	localparam logic [7:0] MDE_OFS_MAP_B_LO   = 8'h2d;
	localparam logic [7:0] MDE_OFS_MAP_B_HI   = 8'h2e;
	localparam logic [7:0] MDE_OFS_MD_CTL     = 8'h37;
	localparam logic [7:0] MDE_OFS_AXIS_EN    = 8'h38;
	localparam logic [7:0] MDE_OFS_MLVL_H     = 8'h39;
	localparam logic [7:0] MDE_OFS_MLVL_L     = 8'h3a;
	localparam logic [7:0] MDE_OFS_MTIME_H    = 8'h3b;
	localparam logic [7:0] MDE_OFS_MTIME_M    = 8'h3c;
	localparam logic [7:0] MDE_OFS_MTIME_L    = 8'h3d;
	localparam logic [7:0] MDE_OFS_SLVL_H     = 8'h3e;
	localparam logic [7:0] MDE_OFS_SLVL_L     = 8'h3f;
	localparam logic [7:0] MDE_OFS_STIME_H    = 8'h40;
	localparam logic [7:0] MDE_OFS_STIME_M    = 8'h41;
	localparam logic [7:0] MDE_OFS_STIME_L    = 8'h42;
	localparam logic [7:0] MDE_OFS_KLVL       = 8'h43;
	localparam logic [7:0] MDE_OFS_KLEN       = 8'h44;
	localparam logic [7:0] MDE_OFS_KLAT       = 8'h45;
	localparam logic [7:0] MDE_OFS_KWIN       = 8'h46;
	localparam logic [7:0] MDE_OFS_KCFG       = 8'h48;

	// Field positions
	localparam int MDE_BIT_SINGLE   = 0;
	localparam int MDE_BIT_DOUBLE   = 1;
	localparam int MDE_BIT_TRIPLE   = 2;
	localparam int MDE_BIT_ACT      = 5;
	localparam int MDE_BIT_STILL    = 6;
	localparam int MDE_BIT_ACT_EN   = 0;
	localparam int MDE_BIT_STILL_EN = 2;
	localparam int MDE_BIT_KTRIPLE  = 2;
	localparam int MDE_CHAN_X       = 4;
	localparam logic [7:0] MDE_MOT_MASK = 8'h60;
	localparam logic [7:0] MDE_TAP_MASK = 8'h07;

	localparam logic [7:0]  MDE_RST_BYTE = 8'h00;
	localparam logic [15:0] MDE_RST_WORD = 16'h0000;
	localparam logic [23:0] MDE_RST_TIME = 24'h000000;

	// Output settling after entering measurement mode
	localparam int unsigned MDE_CLK_PERIOD_NS = 100;
	localparam int unsigned MDE_SETTLE_NS     = 2000000;
	localparam int unsigned MDE_SETTLE_CYC    =
		(MDE_SETTLE_NS + MDE_CLK_PERIOD_NS - 1) / MDE_CLK_PERIOD_NS;

	typedef enum logic [4:0] {
		MDE_K_IDLE   = 5'b00001,
		MDE_K_HIGH   = 5'b00010,
		MDE_K_LATENT = 5'b00100,
		MDE_K_WINDOW = 5'b01000,
		MDE_K_HOLD   = 5'b10000
	} mde_knock_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mde_reg_req_type;

	typedef struct packed {
		logic               valid;
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
	} mde_sample_type;

	typedef struct packed {
		logic [7:0]    operating_mode_select;
		logic [7:0]    chan_en;
		logic [7:0]    map_a_lo;
		logic [7:0]    map_a_hi;
		logic [7:0]    map_b_lo;
		logic [7:0]    map_b_hi;
		logic [7:0]    md_ctl;
		logic [7:0]    axis_en;
		logic [15:0]   act_lvl;
		logic [15:0]   still_lvl;
		logic [23:0]   act_time;
		logic [23:0]   still_time;
		logic [7:0]    k_lvl;
		logic [7:0]    k_len;
		logic [7:0]    k_lat;
		logic [7:0]    k_win;
		logic [7:0]    k_cfg;
		logic [7:0]    status;
		logic [7:0]    rdata;
		logic [23:0]   act_cnt;
		logic [23:0]   still_cnt;
		logic          act_done;
		logic          still_done;
		mde_knock_type kst;
		logic [7:0]    kcnt;
		logic [1:0]    taps;
		logic [15:0]   settle;
		logic          meas;
		logic          pa;
		logic          pa_oe;
		logic          pb;
		logic          pb_oe;
	} mde_state_type;

endpackage : mde_pkg

//--- rtl/mde_motion_event_detector.sv
// Motion event detector: activity, inactivity, tap and interrupt pins.
// Assumes samples and register port come from logic on the same clock.
//
// Contract
// - Flag activity above, inactivity below thresholds
// - Low route byte 0xa0 sends activity to pin a
// - Low route byte 0x40 sends inactivity to pin b
// - Control 0x05 enables activity and inactivity detection
// - Axis enable 0x03 uses x and y only
// - Activity time is three bytes, high first
// - Inactivity time three bytes, counted in samples
// - Activity threshold is high then low byte
// - Inactivity threshold is high then low byte
// - Detect single, double and triple knocks
// - High route byte 0x01 sends single knock to pin a
// - High route byte 0x03 sends double, triple to b
// - Pin is OR of all mapped sources
// - Status register tells which knock occurred
// - Knock level sets the acceleration to exceed
// - Knock length limits time above level
// - Latency waits between knocks; zero disables repeats
// - Window bounds when further knocks count
// - Knock config 0x06: triple enable, z axis
// - Free fall sets inactivity status and pin
// - Output unsettled 2 ms after entering measurement
// - Unmapped pin or reset leaves pin undriven
`timescale 1ns/1ns

module mde_motion_event_detector
	import mde_pkg::*;
#(
	parameter int unsigned SETTLE_CYCLES = MDE_SETTLE_CYC
) (
	input  wire logic            clk,
	input  wire logic            rstn,
	input  wire mde_reg_req_type reg_req,
	output logic [7:0]           reg_rdata,
	input  wire mde_sample_type  sample,
	output logic                 irq_pin_a_o,
	output logic                 irq_pin_a_oe,
	output logic                 irq_pin_b_o,
	output logic                 irq_pin_b_oe
);

	mde_state_type r;
	mde_state_type n;

	logic [15:0] mag_x;
	logic [15:0] mag_y;
	logic [15:0] mag_z;
	logic [15:0] kmag;
	logic [2:0]  used;
	logic        act_any;
	logic        still_all;
	logic        kabove;
	logic        go;
	logic [7:0]  set_b;
	logic [7:0]  clr_b;
	logic [1:0]  taps_n;
	logic [23:0] act_cnt_n;
	logic [23:0] still_cnt_n;

	function automatic logic [15:0] mde_abs(input logic signed [15:0] v);
		logic [15:0] t;
		t = v[15] ? 16'(-v) : 16'(v);
		return t;
	endfunction : mde_abs

	// Knock count to its status bit
	function automatic logic [7:0] mde_knock_bits(input logic [1:0] cnt);
		logic [7:0] b;
		b = 8'h00;
		case (cnt)
			2'd1: b[MDE_BIT_SINGLE] = 1'b1;
			2'd2: b[MDE_BIT_DOUBLE] = 1'b1;
			2'd3: b[MDE_BIT_TRIPLE] = 1'b1;
			default: b = 8'h00;
		endcase
		return b;
	endfunction : mde_knock_bits

	function automatic logic [23:0] mde_sat_inc(input logic [23:0] c);
		logic [23:0] s;
		s = (c == 24'hffffff) ? c : 24'(c + 24'd1);
		return s;
	endfunction : mde_sat_inc

	// Route bytes of pin a to status positions
	function automatic logic [7:0] mde_route_a(input logic [7:0] lo, input logic [7:0] hi);
		logic [7:0] m;
		m = (lo & MDE_MOT_MASK) | (hi & MDE_TAP_MASK);
		return m;
	endfunction : mde_route_a

	// Pin b orders its knock routes double, triple, single,
	// so that 0x03 picks both repeated knocks and leaves single out
	function automatic logic [7:0] mde_route_b(input logic [7:0] lo, input logic [7:0] hi);
		logic [7:0] m;
		m                 = lo & MDE_MOT_MASK;
		m[MDE_BIT_DOUBLE] = hi[0];
		m[MDE_BIT_TRIPLE] = hi[1];
		m[MDE_BIT_SINGLE] = hi[2];
		return m;
	endfunction : mde_route_b

	assign mag_x = mde_abs(sample.x);
	assign mag_y = mde_abs(sample.y);
	assign mag_z = mde_abs(sample.z);

	// An axis counts only when both its channel and its detect bit are on
	assign used = r.axis_en[2:0] & r.chan_en[MDE_CHAN_X +: 3];

	assign act_any = (used[0] && (mag_x > r.act_lvl))
		|| (used[1] && (mag_y > r.act_lvl))
		|| (used[2] && (mag_z > r.act_lvl));

	// Absolute mode: every used axis must sit below, which is free fall
	assign still_all = (used != 3'b000)
		&& (!used[0] || (mag_x < r.still_lvl))
		&& (!used[1] || (mag_y < r.still_lvl))
		&& (!used[2] || (mag_z < r.still_lvl));

	always_comb begin
		case (r.k_cfg[1:0])
			2'd1: kmag = r.chan_en[MDE_CHAN_X + 1] ? mag_y : 16'h0000;
			2'd2: kmag = r.chan_en[MDE_CHAN_X + 2] ? mag_z : 16'h0000;
			default: kmag = r.chan_en[MDE_CHAN_X] ? mag_x : 16'h0000;
		endcase
	end

	// Level compares against the upper byte of the magnitude
	assign kabove = kmag[15:8] > r.k_lvl;

	// Samples are ignored until the output has settled
	assign go = sample.valid && r.meas && (r.settle == 16'h0000);

	assign act_cnt_n   = mde_sat_inc(r.act_cnt);
	assign still_cnt_n = mde_sat_inc(r.still_cnt);
	assign taps_n      = 2'(r.taps + 2'd1);

	always_comb begin
		n     = r;
		set_b = 8'h00;
		clr_b = 8'h00;

		// Register writes
		if (reg_req.wr) begin
			case (reg_req.addr)
				MDE_OFS_OPERATING_MODE_SELECT:  n.operating_mode_select = reg_req.wdata;
				MDE_OFS_CHAN_EN:  n.chan_en = reg_req.wdata;
				MDE_OFS_MAP_A_LO: n.map_a_lo = reg_req.wdata;
				MDE_OFS_MAP_A_HI: n.map_a_hi = reg_req.wdata;
				MDE_OFS_MAP_B_LO: n.map_b_lo = reg_req.wdata;
				MDE_OFS_MAP_B_HI: n.map_b_hi = reg_req.wdata;
				MDE_OFS_MD_CTL:   n.md_ctl = reg_req.wdata;
				MDE_OFS_AXIS_EN:  n.axis_en = reg_req.wdata;
				MDE_OFS_MLVL_H:   n.act_lvl[15:8] = reg_req.wdata;
				MDE_OFS_MLVL_L:   n.act_lvl[7:0] = reg_req.wdata;
				MDE_OFS_MTIME_H:  n.act_time[23:16] = reg_req.wdata;
				MDE_OFS_MTIME_M:  n.act_time[15:8] = reg_req.wdata;
				MDE_OFS_MTIME_L:  n.act_time[7:0] = reg_req.wdata;
				MDE_OFS_SLVL_H:   n.still_lvl[15:8] = reg_req.wdata;
				MDE_OFS_SLVL_L:   n.still_lvl[7:0] = reg_req.wdata;
				MDE_OFS_STIME_H:  n.still_time[23:16] = reg_req.wdata;
				MDE_OFS_STIME_M:  n.still_time[15:8] = reg_req.wdata;
				MDE_OFS_STIME_L:  n.still_time[7:0] = reg_req.wdata;
				MDE_OFS_KLVL:     n.k_lvl = reg_req.wdata;
				MDE_OFS_KLEN:     n.k_len = reg_req.wdata;
				MDE_OFS_KLAT:     n.k_lat = reg_req.wdata;
				MDE_OFS_KWIN:     n.k_win = reg_req.wdata;
				MDE_OFS_KCFG:     n.k_cfg = reg_req.wdata;
				default: n.operating_mode_select = n.operating_mode_select;
			endcase
		end

		// Register reads; status clears on read
		if (reg_req.rd) begin
			case (reg_req.addr)
				MDE_OFS_STATUS: begin
					n.rdata = r.status;
					clr_b   = r.status;
				end
				MDE_OFS_OPERATING_MODE_SELECT:  n.rdata = r.operating_mode_select;
				MDE_OFS_CHAN_EN:  n.rdata = r.chan_en;
				MDE_OFS_MAP_A_LO: n.rdata = r.map_a_lo;
				MDE_OFS_MAP_A_HI: n.rdata = r.map_a_hi;
				MDE_OFS_MAP_B_LO: n.rdata = r.map_b_lo;
				MDE_OFS_MAP_B_HI: n.rdata = r.map_b_hi;
				MDE_OFS_MD_CTL:   n.rdata = r.md_ctl;
				MDE_OFS_AXIS_EN:  n.rdata = r.axis_en;
				MDE_OFS_MLVL_H:   n.rdata = r.act_lvl[15:8];
				MDE_OFS_MLVL_L:   n.rdata = r.act_lvl[7:0];
				MDE_OFS_MTIME_H:  n.rdata = r.act_time[23:16];
				MDE_OFS_MTIME_M:  n.rdata = r.act_time[15:8];
				MDE_OFS_MTIME_L:  n.rdata = r.act_time[7:0];
				MDE_OFS_SLVL_H:   n.rdata = r.still_lvl[15:8];
				MDE_OFS_SLVL_L:   n.rdata = r.still_lvl[7:0];
				MDE_OFS_STIME_H:  n.rdata = r.still_time[23:16];
				MDE_OFS_STIME_M:  n.rdata = r.still_time[15:8];
				MDE_OFS_STIME_L:  n.rdata = r.still_time[7:0];
				MDE_OFS_KLVL:     n.rdata = r.k_lvl;
				MDE_OFS_KLEN:     n.rdata = r.k_len;
				MDE_OFS_KLAT:     n.rdata = r.k_lat;
				MDE_OFS_KWIN:     n.rdata = r.k_win;
				MDE_OFS_KCFG:     n.rdata = r.k_cfg;
				default:          n.rdata = 8'h00;
			endcase
		end

		// Measurement entry and settling
		n.meas = (r.operating_mode_select[3:0] != 4'h0);
		if (n.meas && !r.meas) begin
			n.settle = 16'(SETTLE_CYCLES);
		end else if (r.settle != 16'h0000) begin
			n.settle = 16'(r.settle - 16'd1);
		end

		// Activity: consecutive samples above the level
		if (!r.meas || !r.md_ctl[MDE_BIT_ACT_EN]) begin
			n.act_cnt  = MDE_RST_TIME;
			n.act_done = 1'b0;
		end else if (go) begin
			if (act_any) begin
				n.act_cnt = act_cnt_n;
				if (!r.act_done && (act_cnt_n >= r.act_time)) begin
					set_b[MDE_BIT_ACT] = 1'b1;
					n.act_done = 1'b1;
				end
			end else begin
				n.act_cnt  = MDE_RST_TIME;
				n.act_done = 1'b0;
			end
		end

		// Inactivity: time counted in output samples
		if (!r.meas || !r.md_ctl[MDE_BIT_STILL_EN]) begin
			n.still_cnt  = MDE_RST_TIME;
			n.still_done = 1'b0;
		end else if (go) begin
			if (still_all) begin
				n.still_cnt = still_cnt_n;
				if (!r.still_done && (still_cnt_n >= r.still_time)) begin
					set_b[MDE_BIT_STILL] = 1'b1;
					n.still_done = 1'b1;
				end
			end else begin
				n.still_cnt  = MDE_RST_TIME;
				n.still_done = 1'b0;
			end
		end

		// Knock sequencer, stepped once per sample
		if (!r.meas) begin
			n.kst  = MDE_K_IDLE;
			n.kcnt = 8'h00;
			n.taps = 2'd0;
		end else if (go) begin
			case (r.kst)
				MDE_K_IDLE: begin
					if (kabove) begin
						n.kst  = MDE_K_HIGH;
						n.kcnt = 8'd1;
						n.taps = 2'd0;
					end
				end
				MDE_K_HIGH: begin
					if (kabove) begin
						if (r.kcnt >= r.k_len) begin
							set_b  = set_b | mde_knock_bits(r.taps);
							n.kst  = MDE_K_HOLD;
						end else begin
							n.kcnt = 8'(r.kcnt + 8'd1);
						end
					end else if ((taps_n == 2'd3) || (r.k_lat == 8'h00)
						|| ((taps_n == 2'd2) && !r.k_cfg[MDE_BIT_KTRIPLE])) begin
						set_b = set_b | mde_knock_bits(taps_n);
						n.kst = MDE_K_IDLE;
					end else begin
						n.taps = taps_n;
						n.kcnt = 8'h00;
						n.kst  = MDE_K_LATENT;
					end
				end
				MDE_K_LATENT: begin
					if (8'(r.kcnt + 8'd1) >= r.k_lat) begin
						n.kcnt = 8'h00;
						n.kst  = MDE_K_WINDOW;
					end else begin
						n.kcnt = 8'(r.kcnt + 8'd1);
					end
				end
				MDE_K_WINDOW: begin
					if (kabove) begin
						n.kcnt = 8'd1;
						n.kst  = MDE_K_HIGH;
					end else if (8'(r.kcnt + 8'd1) >= r.k_win) begin
						set_b = set_b | mde_knock_bits(r.taps);
						n.kst = MDE_K_IDLE;
					end else begin
						n.kcnt = 8'(r.kcnt + 8'd1);
					end
				end
				MDE_K_HOLD: begin
					// Too long for a knock; wait for the level to drop
					if (!kabove) begin
						n.kst = MDE_K_IDLE;
					end
				end
				default: n.kst = MDE_K_IDLE;
			endcase
		end

		// A new event beats a clear-on-read in the same cycle
		n.status = (r.status & ~clr_b) | set_b;

		// Pins follow the sticky flags of every mapped source
		n.pa    = |(r.status & mde_route_a(r.map_a_lo, r.map_a_hi));
		n.pb    = |(r.status & mde_route_b(r.map_b_lo, r.map_b_hi));
		n.pa_oe = |mde_route_a(r.map_a_lo, r.map_a_hi);
		n.pb_oe = |mde_route_b(r.map_b_lo, r.map_b_hi);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r            <= '0;
			r.operating_mode_select    <= MDE_RST_BYTE;
			r.act_lvl    <= MDE_RST_WORD;
			r.still_lvl  <= MDE_RST_WORD;
			r.act_time   <= MDE_RST_TIME;
			r.still_time <= MDE_RST_TIME;
			r.kst        <= MDE_K_IDLE;
			r.pa_oe      <= 1'b0;
			r.pb_oe      <= 1'b0;
		end else begin
			r <= n;
		end
	end

	assign reg_rdata    = r.rdata;
	assign irq_pin_a_o  = r.pa;
	assign irq_pin_a_oe = r.pa_oe;
	assign irq_pin_b_o  = r.pb;
	assign irq_pin_b_oe = r.pb_oe;

endmodule : mde_motion_event_detector

//--- bench/mde_properties.sv
// Assertions on the register port and interrupt pins of the detector.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns

module mde_properties
	import mde_pkg::*;
(
	input wire logic            clk,
	input wire logic            rstn,
	input wire mde_reg_req_type reg_req,
	input wire logic [7:0]      reg_rdata,
	input wire mde_sample_type  sample,
	input wire logic            irq_pin_a_o,
	input wire logic            irq_pin_a_oe,
	input wire logic            irq_pin_b_o,
	input wire logic            irq_pin_b_oe
);
	logic [7:0] alo_r, ahi_r, blo_r, bhi_r;
	logic       a_oe_r, b_oe_r;

	// Shadow route bytes; the checker cannot see the register file
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{alo_r, ahi_r, blo_r, bhi_r, a_oe_r, b_oe_r} <= '0;
		end else begin
			a_oe_r <= |(alo_r & MDE_MOT_MASK) || |(ahi_r & MDE_TAP_MASK);
			b_oe_r <= |(blo_r & MDE_MOT_MASK) || |(bhi_r & MDE_TAP_MASK);
			if (reg_req.wr) begin
				case (reg_req.addr)
					MDE_OFS_MAP_A_LO: alo_r <= reg_req.wdata;
					MDE_OFS_MAP_A_HI: ahi_r <= reg_req.wdata;
					MDE_OFS_MAP_B_LO: blo_r <= reg_req.wdata;
					MDE_OFS_MAP_B_HI: bhi_r <= reg_req.wdata;
					default: ;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence rd_st_s;
		reg_req.rd && reg_req.addr == MDE_OFS_STATUS;
	endsequence
	// A sample taken with the first read would set a bit again
	sequence clear_s;
		(reg_req.rd && reg_req.addr == MDE_OFS_STATUS && !sample.valid) ##1 rd_st_s;
	endsequence

	idle_undriven_a: assert property ((irq_pin_a_oe || !irq_pin_a_o)
		&& (irq_pin_b_oe || !irq_pin_b_o))
		else $error("pin active while undriven");
	pin_a_oe_a: assert property (irq_pin_a_oe == a_oe_r)
		else $error("pin a enable wrong");
	pin_b_oe_a: assert property (irq_pin_b_oe == b_oe_r)
		else $error("pin b enable wrong");
	route_read_a: assert property (reg_req.rd && reg_req.addr == MDE_OFS_MAP_A_LO
		|=> reg_rdata == $past(alo_r))
		else $error("route byte read wrong");
	unmapped_read_a: assert property (reg_req.rd && reg_req.addr == 8'h00
		|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!reg_req.rd |=> $stable(reg_rdata))
		else $error("read data moved");
	status_clear_a: assert property (clear_s |=> reg_rdata == 8'h00)
		else $error("status not cleared");
	pin_cause_a: assert property ($rose(irq_pin_a_o) |-> $past(sample.valid, 3)
		|| $past(sample.valid, 2) || $past(reg_req.wr, 2) || $past(reg_req.wr, 3))
		else $error("pin rose without cause");
	pin_sticky_a: assert property ($fell(irq_pin_a_o) |-> $past(reg_req.rd, 2) || $past(reg_req.rd, 3)
		|| $past(reg_req.wr, 2) || $past(reg_req.wr, 3))
		else $error("pin fell without read");
endmodule : mde_properties

bind mde_motion_event_detector mde_properties u_mde_properties (
	.clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata), .sample(sample),
	.irq_pin_a_o(irq_pin_a_o), .irq_pin_a_oe(irq_pin_a_oe),
	.irq_pin_b_o(irq_pin_b_o), .irq_pin_b_oe(irq_pin_b_oe)
);

//--- bench/mde_host_model.sv
// Host-side view of the two interrupt pins with their bus keepers.
// Assumes the detector's pin levels and enables feed it directly.
`timescale 1ns/1ns

module mde_host_model (
	input  wire logic clk,
	input  wire logic pin_a_o,
	input  wire logic pin_a_oe,
	input  wire logic pin_b_o,
	input  wire logic pin_b_oe,
	output logic      lvl_a,
	output logic      lvl_b
);
	logic last_a_r = 1'b0;
	logic last_b_r = 1'b0;

	always_ff @(posedge clk) begin
		if (pin_a_oe) last_a_r <= pin_a_o;
		if (pin_b_oe) last_b_r <= pin_b_o;
	end
	// Undriven pin shows the inverse, so a stale level never passes
	assign lvl_a = pin_a_oe ? pin_a_o : !last_a_r;
	assign lvl_b = pin_b_oe ? pin_b_o : !last_b_r;
endmodule : mde_host_model

//--- bench/motion_event_detector_test.sv
// Self-checking bench of the motion event detector.
// Assumes the host model resolves the pins and the checker is bound.
`timescale 1ns/1ns

module motion_event_detector_test
	import mde_pkg::*;
;
	localparam int SETTLE = 20;
	logic            clk = 1'b0;
	logic            rstn = 1'b0;
	mde_reg_req_type reg_req = '0;
	mde_sample_type  sample = '0;
	logic [7:0]      reg_rdata;
	logic            pa_o, pa_oe, pb_o, pb_oe, lvl_a, lvl_b;
	int              n_errors = 0;
	int              total_checks = 0;
	int              cycles = 0;

	mde_motion_event_detector #(.SETTLE_CYCLES(SETTLE)) u_mde_motion_event_detector (
		.clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata), .sample(sample),
		.irq_pin_a_o(pa_o), .irq_pin_a_oe(pa_oe), .irq_pin_b_o(pb_o), .irq_pin_b_oe(pb_oe));
	mde_host_model u_mde_host_model (.clk(clk), .pin_a_o(pa_o), .pin_a_oe(pa_oe),
		.pin_b_o(pb_o), .pin_b_oe(pb_oe), .lvl_a(lvl_a), .lvl_b(lvl_b));

	initial begin
		forever #50 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	// Generous ceiling; the whole run needs about 2200 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_req <= {1'b1, 1'b0, a, d};
		@(posedge clk);
		reg_req <= '0;
		@(posedge clk);
	endtask : wr

	// Held for n cycles, so n reads of one offset run back to back
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input int n = 1);
		reg_req <= {1'b0, 1'b1, a, 8'h00};
		repeat (n) @(posedge clk);
		reg_req <= '0;
		#1 chk(reg_rdata, exp);
		@(posedge clk);
	endtask : rd

	task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z,
		input int n);
		repeat (n) begin
			sample <= {1'b1, x, y, z};
			@(posedge clk);
			sample.valid <= 1'b0;
			@(posedge clk);
		end
	endtask : smp

	// Pin follows status one edge after the taking edge
	task automatic pins(input logic a, input logic b);
		repeat (3) @(posedge clk);
		#1 chk({6'h00, lvl_a, lvl_b}, {6'h00, a, b});
		@(posedge clk);
	endtask : pins

	task automatic t_reset();
		chk({6'h00, pa_oe, pb_oe}, 8'h00);
		rd(MDE_OFS_MAP_A_LO, MDE_RST_BYTE);
		rd(8'h00, 8'h00);
		wr(MDE_OFS_STATUS, 8'hff);
		rd(MDE_OFS_STATUS, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_motion();
		wr(MDE_OFS_MAP_A_LO, 8'ha0);
		wr(MDE_OFS_MAP_B_LO, 8'h40);
		wr(MDE_OFS_MD_CTL, 8'h05);
		wr(MDE_OFS_AXIS_EN, 8'h03);
		wr(MDE_OFS_CHAN_EN, 8'h70);
		wr(MDE_OFS_MTIME_L, 8'hc8);
		wr(MDE_OFS_STIME_L, 8'hc8);
		wr(MDE_OFS_MLVL_H, 8'h01);
		wr(MDE_OFS_SLVL_L, 8'h22);
		rd(MDE_OFS_MTIME_L, 8'hc8);
		rd(MDE_OFS_MAP_A_LO, 8'ha0);
		wr(MDE_OFS_OPERATING_MODE_SELECT, 8'h02);
		repeat (SETTLE + 4) @(posedge clk);
		smp(16'h0050, 16'h0050, 16'h7000, 200);
		pins(1'b0, 1'b0);
		smp(16'h0000, 16'hfe00, 16'h0000, 199);
		pins(1'b0, 1'b0);
		smp(16'h0000, 16'hfe00, 16'h0000, 1);
		pins(1'b1, 1'b0);
		chk({6'h00, pa_oe, pb_oe}, 8'h03);
		rd(MDE_OFS_STATUS, 8'h20);
		pins(1'b0, 1'b0);
		smp(16'h0021, 16'hffdf, 16'h4000, 199);
		pins(1'b0, 1'b0);
		smp(16'h0021, 16'hffdf, 16'h4000, 1);
		pins(1'b0, 1'b1);
		rd(MDE_OFS_STATUS, 8'h00, 2);
		$display("test motion done");
	endtask : t_motion

	task automatic t_settle();
		wr(MDE_OFS_OPERATING_MODE_SELECT, 8'h00);
		wr(MDE_OFS_MTIME_L, 8'h01);
		wr(MDE_OFS_OPERATING_MODE_SELECT, 8'h02);
		smp(16'h0200, 16'h0000, 16'h0000, SETTLE / 2 - 2);
		pins(1'b0, 1'b0);
		repeat (SETTLE) @(posedge clk);
		smp(16'h0200, 16'h0000, 16'h0000, 1);
		pins(1'b1, 1'b0);
		rd(MDE_OFS_STATUS, 8'h20);
		$display("test settle done");
	endtask : t_settle

	task automatic t_knock();
		// Leaving measurement drops knock state left by the settle test
		wr(MDE_OFS_OPERATING_MODE_SELECT, 8'h00);
		wr(MDE_OFS_MD_CTL, 8'h00);
		wr(MDE_OFS_MAP_A_HI, 8'h01);
		wr(MDE_OFS_MAP_B_HI, 8'h03);
		wr(MDE_OFS_KLVL, 8'h44);
		wr(MDE_OFS_KLEN, 8'h40);
		wr(MDE_OFS_KLAT, 8'h20);
		wr(MDE_OFS_KWIN, 8'h7d);
		wr(MDE_OFS_KCFG, 8'h06);
		wr(MDE_OFS_OPERATING_MODE_SELECT, 8'h03);
		repeat (SETTLE + 4) @(posedge clk);
		// Large x throughout: a wrong axis choice would abort as too long
		smp(16'h7000, 16'h0000, 16'h44ff, 2);
		smp(16'h7000, 16'h0000, 16'h0000, 200);
		rd(MDE_OFS_STATUS, 8'h00);
		repeat (3) begin
			smp(16'h7000, 16'h0000, 16'h4500, 2);
			smp(16'h7000, 16'h0000, 16'h0000, 40);
		end
		pins(1'b0, 1'b1);
		rd(MDE_OFS_STATUS, 8'h04);
		wr(MDE_OFS_KLAT, 8'h00);
		smp(16'h7000, 16'h0000, 16'h4500, 70);
		smp(16'h7000, 16'h0000, 16'h0000, 1);
		rd(MDE_OFS_STATUS, 8'h00);
		smp(16'h7000, 16'h0000, 16'h4500, 2);
		smp(16'h7000, 16'h0000, 16'h0000, 1);
		pins(1'b1, 1'b0);
		rd(MDE_OFS_STATUS, 8'h01);
		$display("test knock done");
	endtask : t_knock

	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_motion();
		t_settle();
		t_knock();
		give_verdict();
	end
endmodule : motion_event_detector_test
